// ==== verif/cpu_bus_model.sv ====
// Purpose: Processor card model giving machine states and phase one.
// Assumes: Three clocks per state, T1 to T3.
// Notes: It never stalls; waits show only as T3 counts.
`timescale 1ns/1ns
module cpu_bus_model (
  input wire logic mclk,
  input wire logic rst,
  output logic t1,
  output logic t2,
  output logic t3,
  output logic sync,
  output logic phi1
);
  logic [3:0] stQ;
  logic [3:0] stD;
  logic [1:0] phQ;
  logic [1:0] phD;
  // Step the machine states; phase one runs free like the real clock.
  always_comb begin
    stD = (stQ == 4'h8) ? 4'h0 : stQ + 4'h1;
    phD = phQ + 2'h1;
  end
  always_ff @(posedge mclk) begin
    stQ <= rst ? 4'h0 : stD;
    phQ <= rst ? 2'h0 : phD;
  end
  // Decode states; the marker opens each T1.
  assign t1 = stQ < 4'h3;
  assign t2 = (stQ > 4'h2) && (stQ < 4'h6);
  assign t3 = stQ > 4'h5;
  assign sync = stQ < 4'h2;
  assign phi1 = phQ[1];
endmodule // cpu_bus_model

// ==== verif/dram_refresh_chk.sv ====
// Purpose: Port assertions for the DRAM card controller.
// Assumes: Straps change only while the card is idle.
// Notes: Attached by bind.
`timescale 1ns/1ns
module dram_refresh_chk
  import dram_ctl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic lateCpu,
  input wire cpu_status_s cpuStat,
  input wire logic [DATA_W-1:0] readData,
  input wire logic readDataOe,
  input wire logic waitReq,
  input wire logic refreshActive,
  input wire logic busy,
  input wire logic ctlReleased
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // A cycle holds busy four clocks; a refresh then ends.
  sequence s_mem;
    busy [*4];
  endsequence
  sequence s_ref;
    refreshActive [*4] ##1 !refreshActive;
  endsequence
  reset_idle_a: assert property ($fell(rst) |->
    !(busy || waitReq || readDataOe || refreshActive || ctlReleased))
    else $error("outputs active after reset");
  early_wait_a: assert property (!lateCpu && !$past(lateCpu, 3) |-> !waitReq)
    else $error("wait asked of earlier processor");
  hold_release_a: assert property ($rose(cpuStat.holdAck) |-> ##[2:3] ctlReleased)
    else $error("lines not released");
  hold_wait_a: assert property (ctlReleased && $past(ctlReleased) |-> !waitReq)
    else $error("wait asked under hold");
  ref_busy_a: assert property (refreshActive |-> busy)
    else $error("refresh without busy");
  mem_cycle_a: assert property ($rose(busy) |-> s_mem)
    else $error("memory cycle too short");
  ref_cycle_a: assert property ($rose(refreshActive) |-> s_ref)
    else $error("refresh length wrong");
  data_hold_a: assert property (readDataOe && $past(readDataOe) |-> $stable(readData))
    else $error("read data moved");
endmodule // dram_refresh_chk
bind dram_refresh_ctl dram_refresh_chk u_dram_refresh_chk (.mclk(mclk), .rst(rst),
  .lateCpu(lateCpu), .cpuStat(cpuStat), .readData(readData), .readDataOe(readDataOe),
  .waitReq(waitReq), .refreshActive(refreshActive), .busy(busy), .ctlReleased(ctlReleased));

// ==== verif/test_dram_refresh_ctl.sv ====
// Purpose: Self-checking bench for the DRAM card controller.
// Assumes: The bus model gives machine states and phase one.
// Notes: Refresh counts are cut short by parameters.
`timescale 1ns/1ns
module test_dram_refresh_ctl
  import dram_ctl_pkg::*;
;
  localparam int EI = 10;
  localparam int LR = 30;
  localparam int LI = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic lateCpu = 1'b0;
  logic halted = 1'b0;
  logic holdAck = 1'b0;
  logic [3:0] strb = 4'h0;
  logic [ADDR_W-1:0] cAddr = 16'h0000;
  logic [ADDR_W-1:0] dAddr = 16'h0000;
  logic [DATA_W-1:0] cDat = 8'h00;
  logic [DATA_W-1:0] dDat = 8'h00;
  logic t1, t2, t3, sync, phi1, readDataOe, waitReq, refreshActive, busy, ctlReleased;
  logic [DATA_W-1:0] readData;
  logic [7:0] flag;
  cpu_status_s stat;
  int miscompares = 0;
  int comparisons = 0;
  int waited;
  bit seenWait;
  // Strobes: processor read, processor write, DMA read, DMA write.
  assign stat = {t1, t2, t3, sync, halted, holdAck, strb[0], strb[1]};
  assign flag = {!readDataOe, !busy, !ctlReleased, ctlReleased, !refreshActive,
    refreshActive, readDataOe, busy};
  // Half period of 2 ns gives 250 MHz.
  always #2 mclk = ~mclk;
  cpu_bus_model u_cpu_bus_model (.mclk(mclk), .rst(rst), .t1(t1), .t2(t2), .t3(t3),
    .sync(sync), .phi1(phi1));
  dram_refresh_ctl #(.EARLY_IDLE_CYC(EI), .LATE_RUN_CYC(LR), .LATE_IDLE_CYC(LI))
    u_dram_refresh_ctl (.mclk(mclk), .rst(rst), .lateCpu(lateCpu), .cardSel(2'h1),
    .phi1(phi1), .cpuStat(stat), .cpuAddr(cAddr), .cpuData(cDat), .dmaRead(strb[2]),
    .dmaWrite(strb[3]), .dmaAddr(dAddr), .dmaData(dDat), .readData(readData),
    .readDataOe(readDataOe), .waitReq(waitReq), .refreshActive(refreshActive), .busy(busy),
    .ctlReleased(ctlReleased));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait on one flag; a hang ends the run.
  task automatic waitOn(input int k, input int lim);
    waited = 0;
    do begin
      @(posedge mclk);
      #1;
      waited++;
      seenWait |= waitReq;
      if (waited > lim) begin
        miscompares++;
        $display("MISMATCH flag %0d expected 1 seen 0", k);
        conclude();
      end
    end while (flag[k] !== 1'b1);
  endtask
  // The idle side of the bus carries inverted values to catch a wrong select.
  task automatic access(input bit dma, input bit wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    cAddr <= dma ? ~a : a;
    dAddr <= dma ? a : ~a;
    cDat <= dma ? ~d : d;
    dDat <= dma ? d : ~d;
    strb <= 4'h1 << {dma, wr};
    if (a[15:14] != 2'h1) begin
      repeat (16) @(posedge mclk);
      #1;
      chk("foreign readDataOe", 8'h00, {7'h0, readDataOe});
    end else if (wr) begin
      waitOn(0, 60);
      waitOn(6, 20);
    end else begin
      waitOn(1, 80);
      chk("readData", d, readData);
    end
    @(posedge mclk);
    strb <= 4'h0;
    waitOn(7, 20);
    repeat (2) @(posedge mclk);
  endtask
  // Start-to-start refresh spacing, skipping the first one after a mode change.
  task automatic period(input string what, input int cyc);
    int n;
    waitOn(2, 600);
    waitOn(3, 20);
    waitOn(2, 600);
    waitOn(3, 20);
    n = waited;
    waitOn(2, 600);
    n += waited;
    chk(what, 8'h01, {7'h0, n >= cyc - 6 && n <= cyc + 6});
  endtask
  ////////////////////////////////////////
  task automatic tEarly();
    seenWait = 1'b0;
    access(0, 1, 16'h4123, 8'hA5);
    access(0, 1, 16'h7FFF, 8'h5A);
    access(0, 1, 16'h8123, 8'h3C);
    access(0, 0, 16'h4123, 8'hA5);
    access(0, 0, 16'h7FFF, 8'h5A);
    access(0, 0, 16'h0123, 8'h00);
    chk("early waitReq", 8'h00, {7'h0, seenWait});
    $display("test early done");
  endtask
  task automatic tLate();
    int refs;
    logic prev;
    @(posedge mclk);
    lateCpu <= 1'b1;
    repeat (4) @(posedge mclk);
    seenWait = 1'b0;
    access(0, 0, 16'h4123, 8'hA5);
    chk("late waitReq", 8'h01, {7'h0, seenWait});
    access(0, 1, 16'h5000, 8'h96);
    access(0, 0, 16'h5000, 8'h96);
    refs = 0;
    for (int i = 0; i < 240; i++) begin
      prev = refreshActive;
      @(posedge mclk);
      #1;
      refs += int'(refreshActive && !prev);
    end
    chk("run refreshes", 8'h01, {7'h0, refs >= 240 / (LR + 28) && refs <= 240 / LR + 1});
    $display("test late done");
  endtask
  task automatic tIdle();
    @(posedge mclk);
    halted <= 1'b1;
    period("late idle period", LI * 4);
    @(posedge mclk);
    lateCpu <= 1'b0;
    period("early idle period", EI * 4);
    @(posedge mclk);
    halted <= 1'b0;
    $display("test idle done");
  endtask
  task automatic tDma();
    @(posedge mclk);
    lateCpu <= 1'b1;
    holdAck <= 1'b1;
    waitOn(4, 10);
    seenWait = 1'b0;
    @(posedge mclk);
    cAddr <= 16'h4123;
    strb <= 4'h1;
    repeat (16) @(posedge mclk);
    #1;
    chk("read under hold", 8'h00, {7'h0, readDataOe});
    @(posedge mclk);
    strb <= 4'h0;
    access(1, 1, 16'h6001, 8'hC3);
    access(1, 0, 16'h6001, 8'hC3);
    chk("hold waitReq", 8'h00, {7'h0, seenWait});
    @(posedge mclk);
    holdAck <= 1'b0;
    waitOn(5, 10);
    access(0, 0, 16'h6001, 8'hC3);
    $display("test dma done");
  endtask
  // Reset for twelve clocks, then each scenario in turn.
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk("reset outputs", 8'h00, {3'h0, busy, waitReq, readDataOe, refreshActive, ctlReleased});
    chk("reset readData", 8'h00, readData);
    tEarly();
    tLate();
    tIdle();
    tDma();
    conclude();
  end
endmodule // test_dram_refresh_ctl

// ==== verilog/dram_ctl_pkg.sv ====
// Purpose: Shared constants and carriers for the microprocessor DRAM card controller.
// Assumes: One clock, mclk at 250 MHz.
// Notes: Times are kept in their own units and converted to cycles here.
package dram_ctl_pkg;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int ADDR_W = 16;
  localparam int CARD_ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int WORDS = 16384;
  localparam int ROW_W = 7;

  // Timer refresh periods, in nanoseconds as printed in microseconds times 1000.
  localparam int EARLY_IDLE_REF_NS = 7500;
  localparam int LATE_RUN_REF_NS = 31000;
  localparam int LATE_IDLE_REF_NS = 25000;
  // Longest times round down to whole cycles.
  localparam int EARLY_IDLE_REF_CYC = (EARLY_IDLE_REF_NS * 1000) / CLK_PERIOD_PS;
  localparam int LATE_RUN_REF_CYC = (LATE_RUN_REF_NS * 1000) / CLK_PERIOD_PS;
  localparam int LATE_IDLE_REF_CYC = (LATE_IDLE_REF_NS * 1000) / CLK_PERIOD_PS;

  // Memory cycle length in mclk cycles.
  localparam int MEM_CYC = 4;
  localparam int PHI_CNT_W = 16;

  localparam logic [1:0] CARD_SEL_RESET = 2'h0;
  localparam logic [1:0] WAIT_NONE = 2'h0;
  localparam logic [1:0] WAIT_ONE = 2'h1;
  localparam logic [1:0] WAIT_TWO = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REF = 4'h2,
    ST_READ = 4'h4,
    ST_WRITE = 4'h8
  } mem_state_e;

  // Processor-side status sampled each clock.
  typedef struct packed {
    logic t1;
    logic t2;
    logic t3;
    logic sync;
    logic halted;
    logic holdAck;
    logic memRead;
    logic memWrite;
  } cpu_status_s;

  // One memory access request.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
  } mem_req_s;

endpackage

// ==== verilog/dram_refresh_ctl.sv ====
// Purpose: Timing, refresh and control logic of a 16K x 8 DRAM card.
// Assumes: Processor status arrives on pins; phi1 is sampled and counted on its rises.
// Notes: Storage is modelled as an array; refresh only advances a row counter.
//
// What this block does
// - Card holds 16K x 8, answers its range.
// - Cycles start in step with processor states.
// - Earlier processor never sees a wait request.
// - Earlier processor refreshes inside T1 state.
// - Earlier halt: refresh every 1875 phi1 periods; none starts under hold.
// - Reset puts all control into initial state.
// - Later processor refreshes every 31 us.
// - Later refresh starts on SYNC rise in T1.
// - Refresh collision asks one or two waits.
// - Later read asks one wait, T2 to T3; waitReq stands whenever a wait is owed outside T3, T1 included.
// - Write begun in T3 doubles next wait.
// - Later halt: refresh every 6250 phi1 periods; none starts under hold.
// - Hold acknowledge hands control lines to DMA.
// - Hold acknowledge masks the memory read input.
// - After DMA, withdraw waits, resume normal timing.
`timescale 1ns/1ns
module dram_refresh_ctl
  import dram_ctl_pkg::*;
#(
  parameter int EARLY_IDLE_CYC = EARLY_IDLE_REF_CYC,
  parameter int LATE_RUN_CYC = LATE_RUN_REF_CYC,
  parameter int LATE_IDLE_CYC = LATE_IDLE_REF_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic lateCpu,
  input wire logic [1:0] cardSel,
  input wire logic phi1,
  input wire cpu_status_s cpuStat,
  input wire logic [ADDR_W-1:0] cpuAddr,
  input wire logic [DATA_W-1:0] cpuData,
  input wire logic dmaRead,
  input wire logic dmaWrite,
  input wire logic [ADDR_W-1:0] dmaAddr,
  input wire logic [DATA_W-1:0] dmaData,
  output logic [DATA_W-1:0] readData,
  output logic readDataOe,
  output logic waitReq,
  output logic refreshActive,
  output logic busy,
  output logic ctlReleased
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronizers.

  logic t1S, t1R, t2S, t3S, t3R, syncS, syncR, haltS, holdS, rdS, rdR, wrS, wrR;
  logic phiS, phiR, dRdS, dRdR, dWrS, dWrR;

  edge_sync uT1 (.mclk(mclk), .rst(rst), .din(cpuStat.t1), .level(t1S), .rise(t1R));
  edge_sync uT2 (.mclk(mclk), .rst(rst), .din(cpuStat.t2), .level(t2S), .rise());
  edge_sync uT3 (.mclk(mclk), .rst(rst), .din(cpuStat.t3), .level(t3S), .rise(t3R));
  edge_sync uSy (.mclk(mclk), .rst(rst), .din(cpuStat.sync), .level(syncS), .rise(syncR));
  edge_sync uHl (.mclk(mclk), .rst(rst), .din(cpuStat.halted), .level(haltS), .rise());
  edge_sync uHa (.mclk(mclk), .rst(rst), .din(cpuStat.holdAck), .level(holdS), .rise());
  edge_sync uRd (.mclk(mclk), .rst(rst), .din(cpuStat.memRead), .level(rdS), .rise(rdR));
  edge_sync uWr (.mclk(mclk), .rst(rst), .din(cpuStat.memWrite), .level(wrS), .rise(wrR));
  edge_sync uPh (.mclk(mclk), .rst(rst), .din(phi1), .level(phiS), .rise(phiR));
  edge_sync uDr (.mclk(mclk), .rst(rst), .din(dmaRead), .level(dRdS), .rise(dRdR));
  edge_sync uDw (.mclk(mclk), .rst(rst), .din(dmaWrite), .level(dWrS), .rise(dWrR));

  //////////////////////////////////////////////////////////////////////////////
  // Address and data capture, two stages like the strobes so they align.

  logic [ADDR_W-1:0] aMeta_q, aMeta_d, aSync_q, aSync_d;
  logic [DATA_W-1:0] dMeta_q, dMeta_d, dSync_q, dSync_d;
  logic lateMeta_q, lateMeta_d, late_q, late_d;
  logic [1:0] selMeta_q, selMeta_d, sel_q, sel_d;

  // The hold acknowledge pin is raw here only to choose the source mux.
  always_comb begin
    aMeta_d = cpuStat.holdAck ? dmaAddr : cpuAddr;
    dMeta_d = cpuStat.holdAck ? dmaData : cpuData;
    aSync_d = aMeta_q;
    dSync_d = dMeta_q;
    lateMeta_d = lateCpu;
    late_d = lateMeta_q;
    selMeta_d = cardSel;
    sel_d = selMeta_q;
  end

  // Bus sample stages.
  always_ff @(posedge mclk) begin
    if (rst) begin
      aMeta_q <= '0;
      aSync_q <= '0;
      dMeta_q <= '0;
      dSync_q <= '0;
      lateMeta_q <= 1'b0;
      late_q <= 1'b0;
      selMeta_q <= CARD_SEL_RESET;
      sel_q <= CARD_SEL_RESET;
    end else begin
      aMeta_q <= aMeta_d;
      aSync_q <= aSync_d;
      dMeta_q <= dMeta_d;
      dSync_q <= dSync_d;
      lateMeta_q <= lateMeta_d;
      late_q <= late_d;
      selMeta_q <= selMeta_d;
      sel_q <= sel_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Request decode.

  logic selHit, idleMode, rdGo, wrGo;

  // Each card answers only the 16K range picked by its select straps.
  assign selHit = (aSync_q[ADDR_W-1:CARD_ADDR_W] == sel_q);
  assign idleMode = haltS | holdS;
  // Processor read strobe is masked under hold acknowledge.
  assign rdGo = holdS ? dRdR : (rdR & ~holdS);
  assign wrGo = holdS ? dWrR : wrR;

  //////////////////////////////////////////////////////////////////////////////
  // Refresh pacing. Running, the earlier part uses every T1; the later part
  // uses a 31 us timer, and both fall back to phi1-counted periods when idle.

  logic [PHI_CNT_W-1:0] refCnt_q, refCnt_d;
  logic refDue_q, refDue_d;
  logic [PHI_CNT_W-1:0] period;
  logic refStart;

  always_comb begin
    unique case ({late_q, idleMode})
      2'b01: period = PHI_CNT_W'(EARLY_IDLE_CYC);
      2'b10: period = PHI_CNT_W'(LATE_RUN_CYC);
      2'b11: period = PHI_CNT_W'(LATE_IDLE_CYC);
      default: period = '0;
    endcase
  end

  // Timer advances on phi1 rises when idle; counts are in mclk units of phi1.
  always_comb begin
    refCnt_d = refCnt_q;
    refDue_d = refDue_q;
    if (idleMode ? phiR : 1'b1) begin
      if (refCnt_q >= period - PHI_CNT_W'(1)) begin
        refCnt_d = '0;
        refDue_d = 1'b1;
      end else begin
        refCnt_d = refCnt_q + PHI_CNT_W'(1);
      end
    end
    if (!late_q && !idleMode) begin
      refDue_d = 1'b0;
      refCnt_d = '0;
    end
    // A new due pulse beats the clear made by starting a refresh.
    if (refStart && !(refCnt_d == '0 && refDue_d && !refDue_q)) begin
      refDue_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      refCnt_q <= '0;
      refDue_q <= 1'b0;
    end else begin
      refCnt_q <= refCnt_d;
      refDue_q <= refDue_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Memory sequencer.

  mem_state_e st_q, st_d;
  logic [2:0] cyc_q, cyc_d;
  logic [ROW_W-1:0] row_q, row_d;
  logic pendRd_q, pendRd_d, pendWr_q, pendWr_d;
  logic wrInT3_q, wrInT3_d;
  logic [1:0] waits_q, waits_d;
  logic [CARD_ADDR_W-1:0] accAddr_q, accAddr_d;
  logic [DATA_W-1:0] wReg_q, wReg_d, rReg_q, rReg_d;
  logic oe_q, oe_d;
  logic [DATA_W-1:0] mem [WORDS];

  // Refresh slot: earlier part in T1 of running cycles, later part on SYNC
  // rise in T1, either part on the timer while halted; none starts under hold.
  always_comb begin
    if (idleMode) begin
      refStart = refDue_q & (st_q == ST_IDLE) & ~holdS;
    end else if (late_q) begin
      refStart = refDue_q & syncR & t1S & (st_q == ST_IDLE);
    end else begin
      refStart = t1R & (st_q == ST_IDLE);
    end
  end

  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    row_d = row_q;
    pendRd_d = pendRd_q | (rdGo & selHit);
    pendWr_d = pendWr_q | (wrGo & selHit);
    wrInT3_d = wrInT3_q;
    waits_d = waits_q;
    accAddr_d = accAddr_q;
    wReg_d = wReg_q;
    rReg_d = rReg_q;
    oe_d = oe_q & (rdS | dRdS);
    if (wrGo && selHit) begin
      wReg_d = dSync_q;
      accAddr_d = aSync_q[CARD_ADDR_W-1:0];
      wrInT3_d = t3S;
    end
    if (rdGo && selHit) begin
      accAddr_d = aSync_q[CARD_ADDR_W-1:0];
    end
    unique case (st_q)
      ST_IDLE: begin
        cyc_d = '0;
        // Refresh is checked first so a tie always goes to refresh.
        if (refStart) begin
          st_d = ST_REF;
          if (late_q && (pendRd_d || pendWr_d)) begin
            waits_d = wrInT3_q ? WAIT_TWO : WAIT_ONE;
          end
        end else if (pendWr_q) begin
          st_d = ST_WRITE;
          pendWr_d = 1'b0;
        end else if (pendRd_q) begin
          st_d = ST_READ;
          pendRd_d = 1'b0;
          if (late_q && !holdS) begin
            waits_d = wrInT3_q ? WAIT_TWO : WAIT_ONE;
            wrInT3_d = 1'b0;
          end
        end
      end
      ST_REF: begin
        cyc_d = cyc_q + 3'h1;
        if (cyc_q == 3'(MEM_CYC - 1)) begin
          row_d = row_q + ROW_W'(1);
          st_d = ST_IDLE;
        end
      end
      ST_READ: begin
        cyc_d = cyc_q + 3'h1;
        if (cyc_q == 3'(MEM_CYC - 1)) begin
          rReg_d = mem[accAddr_q];
          oe_d = 1'b1;
          st_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        cyc_d = cyc_q + 3'h1;
        if (cyc_q == 3'(MEM_CYC - 1)) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // One wait is used up at each T3 entry made while waiting, if the sequencer is idle and stays idle.
    if (waits_q != WAIT_NONE && t3R && st_q == ST_IDLE && st_d == ST_IDLE) begin
      waits_d = waits_q - 2'h1;
    end
    // Hold acknowledge, or the earlier part, keeps the wait count at none.
    if (!late_q || holdS) begin
      waits_d = WAIT_NONE;
    end
  end

  // Sequencer registers; all control state starts clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= ST_IDLE;
      cyc_q <= '0;
      row_q <= '0;
      pendRd_q <= 1'b0;
      pendWr_q <= 1'b0;
      wrInT3_q <= 1'b0;
      waits_q <= WAIT_NONE;
      accAddr_q <= '0;
      wReg_q <= '0;
      rReg_q <= '0;
      oe_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cyc_q <= cyc_d;
      row_q <= row_d;
      pendRd_q <= pendRd_d;
      pendWr_q <= pendWr_d;
      wrInT3_q <= wrInT3_d;
      waits_q <= waits_d;
      accAddr_q <= accAddr_d;
      wReg_q <= wReg_d;
      rReg_q <= rReg_d;
      oe_q <= oe_d;
    end
  end

  // Storage array; not reset, as DRAM content is undefined at power-up.
  always_ff @(posedge mclk) begin
    if (st_q == ST_WRITE && cyc_q == 3'(MEM_CYC - 1)) begin
      mem[accAddr_q] <= wReg_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign readData = rReg_q;
  assign readDataOe = oe_q;
  assign waitReq = (waits_q != WAIT_NONE) & t2S | (waits_q != WAIT_NONE) & ~t3S;
  assign refreshActive = (st_q == ST_REF);
  assign busy = (st_q != ST_IDLE);
  assign ctlReleased = holdS;

endmodule // dram_refresh_ctl

// ==== verilog/edge_sync.sv ====
// Purpose: Two-stage synchronizer with rising edge output.
// Assumes: Input is asynchronous to mclk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module edge_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic last_q, last_d;

  // Next values of the synchronizer chain.
  always_comb begin
    meta_d = din;
    sync_d = meta_q;
    last_d = sync_q;
  end

  // Registered chain; reset to constants only.
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      last_q <= last_d;
    end
  end

  assign level = sync_q;
  assign rise = sync_q & ~last_q;

endmodule // edge_sync
